// [hw/asqtc_pkg.sv]
// Package for the converter sequencer and trigger control block
`default_nettype none
package asqtc_pkg;
   // Register map, word offsets (byte address = 4 * index)
   localparam logic [7:0] OFF_PHASE    = 8'h00;
   localparam logic [7:0] OFF_REF      = 8'h01;
   localparam logic [7:0] OFF_ENABLE   = 8'h02;
   localparam logic [7:0] OFF_PTRIG    = 8'h03;
   localparam logic [7:0] OFF_STATUS   = 8'h04;
   localparam logic [7:0] OFF_STCLR    = 8'h05;
   localparam logic [7:0] OFF_SEQCFG0  = 8'h08;
   localparam logic [7:0] OFF_FIFO0    = 8'h10;
   localparam logic [7:0] OFF_LEVEL0   = 8'h18;
   // Field positions
   localparam int PTRIG_WAIT_BIT   = 4;
   localparam int PTRIG_SIGNAL_BIT = 5;
   localparam int CFG_PRIO_LSB     = 4;
   localparam int CFG_MOD_BIT      = 6;
   // Reset values
   localparam logic [3:0] PHASE_RST  = 4'h0;
   localparam logic [1:0] REF_RST    = 2'h0;
   localparam logic [6:0] SEQCFG_RST = 7'h00;
   // Timing
   localparam int SAMPLE_PERIOD_NS = 2000;
   localparam int CLK_PERIOD_NS    = 20;
   localparam int SAMPLE_CYCLES    = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
   localparam int PHASE_STEPS      = 16;
   localparam int PHASE_UNIT       = SAMPLE_CYCLES / PHASE_STEPS;
   // Sequencer depths
   localparam int DEPTH0 = 8;
   localparam int DEPTH1 = 4;
   localparam int DEPTH2 = 4;
   localparam int DEPTH3 = 1;

   typedef enum logic [1:0] {
      REF_SEL_INT      = 2'h0,
      REF_SEL_EXT_HIGH = 2'h1,
      REF_SEL_EXT_LOW  = 2'h2
   } asqtc_ref_t;

   typedef enum logic [3:0] {
      TRIG_SRC_PROC        = 4'h0,
      TRIG_SRC_CMP_FIRST   = 4'h1,
      TRIG_SRC_CMP_SECOND  = 4'h2,
      TRIG_SRC_CMP_THIRD   = 4'h3,
      TRIG_SRC_EXT         = 4'h4,
      TRIG_SRC_TIMER       = 4'h5,
      TRIG_SRC_GEN_FIRST   = 4'h6,
      TRIG_SRC_GEN_SECOND  = 4'h7,
      TRIG_SRC_GEN_THIRD   = 4'h8,
      TRIG_SRC_GEN_FOURTH  = 4'h9,
      TRIG_SRC_ALWAYS      = 4'hF
   } asqtc_src_t;

   typedef enum logic [3:0] {
      ST_IDLE  = 4'b0001,
      ST_DELAY = 4'b0010,
      ST_CONV  = 4'b0100,
      ST_STORE = 4'b1000
   } asqtc_state_t;

   // Trigger inputs grouped together
   typedef struct packed {
      logic [2:0] cmp;
      logic       timer;
      logic [3:0] gen_mod0;
      logic [3:0] gen_mod1;
   } asqtc_trig_t;

   // Per-sequence configuration
   typedef struct packed {
      logic       gen_mod;
      logic [1:0] prio;
      logic [3:0] src;
   } asqtc_cfg_t;
endpackage : asqtc_pkg
`default_nettype wire

// [hw/asqtc_fifo.sv]
// Parameterised synchronous FIFO with valid/ready and level
`default_nettype none
module asqtc_fifo #(
   parameter int WIDTH = 12,
   parameter int DEPTH = 32
) (
   // Clock and reset
   input  wire logic                     clk_i,
   input  wire logic                     rst_i,
   input  wire logic                     ce_i,
   // Fill side
   input  wire logic                     in_valid_i,
   output logic                          in_ready_o,
   input  wire logic [WIDTH-1:0]         in_data_i,
   // Drain side
   output logic                          out_valid_o,
   input  wire logic                     out_ready_i,
   output logic [WIDTH-1:0]              out_data_o,
   output logic [$clog2(DEPTH+1)-1:0]    level_o
);
   localparam int AW = $clog2(DEPTH);
   logic [WIDTH-1:0]           mem_q [DEPTH];
   logic [AW-1:0]              wr_q;
   logic [AW-1:0]              rd_q;
   logic [$clog2(DEPTH+1)-1:0] cnt_q;
   wire                        push = in_valid_i & in_ready_o;
   wire                        pop  = out_valid_o & out_ready_i;

   assign in_ready_o  = (cnt_q != DEPTH[$clog2(DEPTH+1)-1:0]);
   assign out_valid_o = (cnt_q != '0);
   assign out_data_o  = mem_q[rd_q];
   assign level_o     = cnt_q;

   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wr_q  <= '0;
         rd_q  <= '0;
         cnt_q <= '0;
      end else if (ce_i) begin
         if (push) begin
            mem_q[wr_q] <= in_data_i;
            wr_q        <= (wr_q == AW'(DEPTH-1)) ? '0 : wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= (rd_q == AW'(DEPTH-1)) ? '0 : rd_q + 1'b1;
         end
         cnt_q <= cnt_q + {{($clog2(DEPTH+1)-1){1'b0}}, push}
                        - {{($clog2(DEPTH+1)-1){1'b0}}, pop};
      end
   end
endmodule : asqtc_fifo
`default_nettype wire

// [hw/asqtc_top.sv]
// Sequencer trigger, priority, phase delay and result FIFO control
// Operation
// - Trigger-to-start delay selectable in sixteen steps of 6 clocks (21.6 degrees), 0 to 324.
// - One phase setting per module, shared by all four sequences.
// - Processor trigger starts a sequence only if its source is processor.
// - Wait-flag processor trigger held until signal trigger from another module.
// - Reference select internal, external high or external low; readable back.
// - Four sequencers with depths eight, four, four and one.
// - Trigger source from processor, comparators, pin, timer, generators, always.
// - Always trigger captures back to back, yielding to higher priority.
// - Per-sequence select picks generator module zero or one.
// - Two-bit priority; lowest value pending sequence runs first.
// - Each sequencer has its own FIFO with readable sample count.
// - Disabled sequence ignores its trigger; a run already in progress still completes.
// - External trigger arrives on a dedicated input pin.
// - Enabled sequence begins capturing when its trigger is detected.
// - Sticky overflow flag when trigger arrives while FIFO still holds samples.
// - Sticky underflow flag when reading an empty FIFO.
//
// Chosen here: the plain strobed port and the placing of the registers.
`default_nettype none
module asqtc_top #(
   parameter int DATA_W     = 12,
   parameter int FIFO_DEPTH = 32
) (
   // Clock, reset, enable
   input  wire logic                 CLOCK_I,
   input  wire logic                 SRST_I,
   input  wire logic                 CE_I,
   // Register port
   input  wire logic [7:0]           ADDR_I,
   input  wire logic [31:0]          WDATA_I,
   input  wire logic                 WR_I,
   input  wire logic                 RD_I,
   output logic      [31:0]          RDATA_O,
   // Trigger sources
   input  wire asqtc_pkg::asqtc_trig_t TRIG_I,
   input  wire logic                 EXT_TRIG_PIN_I,
   // Cross-module processor trigger sync
   input  wire logic                 SYNC_SIGNAL_I,
   output logic                      SYNC_SIGNAL_O,
   // Converter core
   output logic                      CONV_START_O,
   output logic      [2:0]           CONV_STEP_O,
   input  wire logic                 CONV_DONE_I,
   input  wire logic [DATA_W-1:0]    CONV_DATA_I,
   output logic      [1:0]           REF_SEL_O
);
   ////////////////////////////////////////////////////////////////////////
   function automatic logic [2:0] last_step(input logic [1:0] s);
      unique case (s)
         2'd0:    last_step = 3'(asqtc_pkg::DEPTH0 - 1);
         2'd1:    last_step = 3'(asqtc_pkg::DEPTH1 - 1);
         2'd2:    last_step = 3'(asqtc_pkg::DEPTH2 - 1);
         default: last_step = 3'(asqtc_pkg::DEPTH3 - 1);
      endcase
   endfunction : last_step

   localparam int LW = $clog2(FIFO_DEPTH+1);

   // Pin synchroniser
   logic ext_s1_q;
   logic ext_s2_q;
   logic ext_s3_q;
   logic sig_s1_q;
   logic sig_s2_q;
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
         ext_s3_q <= 1'b0;
         sig_s1_q <= 1'b0;
         sig_s2_q <= 1'b0;
      end else if (CE_I) begin
         ext_s1_q <= EXT_TRIG_PIN_I;
         ext_s2_q <= ext_s1_q;
         ext_s3_q <= ext_s2_q;
         sig_s1_q <= SYNC_SIGNAL_I;
         sig_s2_q <= sig_s1_q;
      end
   end
   wire ext_rise = ext_s2_q & ~ext_s3_q;

   ////////////////////////////////////////////////////////////////////////
   // Registers
   logic [3:0]            phase_q;
   logic [1:0]            ref_q;
   logic [3:0]            en_q;
   logic [3:0]            ovf_q;
   logic [3:0]            unf_q;
   asqtc_pkg::asqtc_cfg_t cfg_q [4];
   logic [3:0]            ptrig_q;
   logic [3:0]            pwait_q;

   wire       wr_ptrig = WR_I && ADDR_I == asqtc_pkg::OFF_PTRIG;
   wire [1:0] wseq     = WDATA_I[1:0];
   wire       w_wait   = WDATA_I[asqtc_pkg::PTRIG_WAIT_BIT];
   wire       w_signal = WDATA_I[asqtc_pkg::PTRIG_SIGNAL_BIT];
   wire       wr_stclr = WR_I && ADDR_I == asqtc_pkg::OFF_STCLR;
   wire       wr_cfg   = WR_I && ADDR_I[7:2] == asqtc_pkg::OFF_SEQCFG0[7:2];
   wire       rd_fifo  = RD_I && ADDR_I[7:2] == asqtc_pkg::OFF_FIFO0[7:2];
   wire [1:0] aseq     = ADDR_I[1:0];

   // Signal flag only notifies other modules; held triggers here release on SYNC_SIGNAL_I
   assign SYNC_SIGNAL_O = wr_ptrig & w_signal;

   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         phase_q <= asqtc_pkg::PHASE_RST;
         ref_q   <= asqtc_pkg::REF_RST;
         en_q    <= '0;
      end else if (CE_I && WR_I) begin
         if (ADDR_I == asqtc_pkg::OFF_PHASE)  phase_q <= WDATA_I[3:0];
         if (ADDR_I == asqtc_pkg::OFF_REF && WDATA_I[1:0] != 2'h3) begin
            ref_q <= WDATA_I[1:0];
         end
         if (ADDR_I == asqtc_pkg::OFF_ENABLE) en_q <= WDATA_I[3:0];
      end
   end
   assign REF_SEL_O = ref_q;

   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         for (int i = 0; i < 4; i++) cfg_q[i] <= asqtc_pkg::SEQCFG_RST;
      end else if (CE_I && wr_cfg) begin
         cfg_q[aseq] <= WDATA_I[6:0];
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Trigger detection per sequence
   logic [3:0] hw_trig;
   logic [3:0] pend_q;
   logic [3:0] start_seq;
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         logic [3:0] g;
         g = cfg_q[i].gen_mod ? TRIG_I.gen_mod1 : TRIG_I.gen_mod0;
         unique case (cfg_q[i].src)
            asqtc_pkg::TRIG_SRC_PROC:       hw_trig[i] = ptrig_q[i];
            asqtc_pkg::TRIG_SRC_CMP_FIRST:  hw_trig[i] = TRIG_I.cmp[0];
            asqtc_pkg::TRIG_SRC_CMP_SECOND: hw_trig[i] = TRIG_I.cmp[1];
            asqtc_pkg::TRIG_SRC_CMP_THIRD:  hw_trig[i] = TRIG_I.cmp[2];
            asqtc_pkg::TRIG_SRC_EXT:        hw_trig[i] = ext_rise;
            asqtc_pkg::TRIG_SRC_TIMER:      hw_trig[i] = TRIG_I.timer;
            asqtc_pkg::TRIG_SRC_GEN_FIRST:  hw_trig[i] = g[0];
            asqtc_pkg::TRIG_SRC_GEN_SECOND: hw_trig[i] = g[1];
            asqtc_pkg::TRIG_SRC_GEN_THIRD:  hw_trig[i] = g[2];
            asqtc_pkg::TRIG_SRC_GEN_FOURTH: hw_trig[i] = g[3];
            asqtc_pkg::TRIG_SRC_ALWAYS:     hw_trig[i] = 1'b1;
            default:                        hw_trig[i] = 1'b0;
         endcase
      end
   end

   // Processor triggers: one-cycle pulse, or held until a signal arrives
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         ptrig_q <= '0;
         pwait_q <= '0;
      end else if (CE_I) begin
         ptrig_q <= pwait_q & {4{sig_s2_q}};
         pwait_q <= sig_s2_q ? '0 : pwait_q;
         if (wr_ptrig && cfg_q[wseq].src == asqtc_pkg::TRIG_SRC_PROC) begin
            if (w_wait) pwait_q[wseq] <= 1'b1;
            else        ptrig_q[wseq] <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Sequencer FSM
   asqtc_pkg::asqtc_state_t st_q;
   logic [1:0]              cur_q;
   logic [2:0]              step_q;
   logic [7:0]              dly_q;
   logic [DATA_W-1:0]       smp_q;
   logic [3:0]              push_ok;
   logic [3:0]              in_rdy;
   logic [LW-1:0]           lvl [4];
   logic [DATA_W-1:0]       fdata [4];
   logic [3:0]              fvalid;

   // Pick the pending sequence with the numerically lowest priority
   logic [1:0] win;
   logic       any;
   always_comb begin
      win = 2'd0;
      any = 1'b0;
      for (int i = 3; i >= 0; i--) begin
         if (pend_q[i] && (!any || cfg_q[i].prio <= cfg_q[win].prio)) begin
            win = 2'(i);
            any = 1'b1;
         end
      end
   end

   // Hardware triggers latch as pending; always re-arms each pass
   always_comb begin
      for (int i = 0; i < 4; i++) start_seq[i] = en_q[i] & hw_trig[i];
   end

   wire launch = (st_q == asqtc_pkg::ST_IDLE) && any;
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         pend_q <= '0;
      end else if (CE_I) begin
         for (int i = 0; i < 4; i++) begin
            if (start_seq[i])                                pend_q[i] <= 1'b1;
            else if (!en_q[i] || (launch && win == 2'(i)))   pend_q[i] <= 1'b0;
         end
      end
   end

   wire [7:0] dly_target = 8'(phase_q * asqtc_pkg::PHASE_UNIT);

   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         st_q   <= asqtc_pkg::ST_IDLE;
         cur_q  <= '0;
         step_q <= '0;
         dly_q  <= '0;
         smp_q  <= '0;
      end else if (CE_I) begin
         unique case (st_q)
            asqtc_pkg::ST_IDLE: if (any) begin
               cur_q  <= win;
               step_q <= '0;
               dly_q  <= '0;
               st_q   <= asqtc_pkg::ST_DELAY;
            end
            asqtc_pkg::ST_DELAY: begin
               if (dly_q >= dly_target) st_q <= asqtc_pkg::ST_CONV;
               else                     dly_q <= dly_q + 8'h01;
            end
            asqtc_pkg::ST_CONV: if (CONV_DONE_I) begin
               smp_q <= CONV_DATA_I;
               st_q  <= asqtc_pkg::ST_STORE;
            end
            asqtc_pkg::ST_STORE: if (in_rdy[cur_q]) begin
               if (step_q == last_step(cur_q)) st_q <= asqtc_pkg::ST_IDLE;
               else begin
                  step_q <= step_q + 3'h1;
                  st_q   <= asqtc_pkg::ST_CONV;
               end
            end
         endcase
      end
   end

   // One start pulse on entering each conversion
   logic conv_q;
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I)    conv_q <= 1'b0;
      else if (CE_I) conv_q <= (st_q == asqtc_pkg::ST_CONV);
   end
   assign CONV_START_O = (st_q == asqtc_pkg::ST_CONV) & ~conv_q;
   assign CONV_STEP_O  = step_q;

   ////////////////////////////////////////////////////////////////////////
   // Result FIFOs, one per sequencer
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_fifo
         assign push_ok[gi] = (st_q == asqtc_pkg::ST_STORE) && cur_q == 2'(gi);
         asqtc_fifo #(.WIDTH(DATA_W), .DEPTH(FIFO_DEPTH)) u_fifo (
            .clk_i       (CLOCK_I),
            .rst_i       (SRST_I),
            .ce_i        (CE_I),
            .in_valid_i  (push_ok[gi]),
            .in_ready_o  (in_rdy[gi]),
            .in_data_i   (smp_q),
            .out_valid_o (fvalid[gi]),
            .out_ready_i (rd_fifo && aseq == 2'(gi)),
            .out_data_o  (fdata[gi]),
            .level_o     (lvl[gi])
         );
      end
   endgenerate

   // Sticky flags: set wins over clear
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         ovf_q <= '0;
         unf_q <= '0;
      end else if (CE_I) begin
         for (int i = 0; i < 4; i++) begin
            if (start_seq[i] && fvalid[i])                  ovf_q[i] <= 1'b1;
            else if (wr_stclr && WDATA_I[i])                ovf_q[i] <= 1'b0;
            if (rd_fifo && aseq == 2'(i) && !fvalid[i])     unf_q[i] <= 1'b1;
            else if (wr_stclr && WDATA_I[i+4])              unf_q[i] <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Read data, one cycle after the strobe
   logic [31:0] rd_d;
   always_comb begin
      rd_d = 32'h0000_0000;
      if (ADDR_I == asqtc_pkg::OFF_PHASE)       rd_d[3:0] = phase_q;
      else if (ADDR_I == asqtc_pkg::OFF_REF)    rd_d[1:0] = ref_q;
      else if (ADDR_I == asqtc_pkg::OFF_ENABLE) rd_d[3:0] = en_q;
      else if (ADDR_I == asqtc_pkg::OFF_STATUS) rd_d[12:0] = {st_q != asqtc_pkg::ST_IDLE,
                                                             pwait_q, unf_q, ovf_q};
      else if (wr_cfg || ADDR_I[7:2] == asqtc_pkg::OFF_SEQCFG0[7:2])
         rd_d[6:0] = cfg_q[aseq];
      else if (rd_fifo)                         rd_d[DATA_W-1:0] = fdata[aseq];
      else if (ADDR_I[7:2] == asqtc_pkg::OFF_LEVEL0[7:2])
         rd_d[LW-1:0] = lvl[aseq];
   end
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I)           RDATA_O <= '0;
      else if (CE_I && RD_I) RDATA_O <= rd_d;
   end
endmodule : asqtc_top
`default_nettype wire

// [tb/asqtc_chk_assertions.sv]
// Port-level checker for the sequencer control block
`default_nettype none
module asqtc_chk #(
   parameter int FIFO_DEPTH = 32
) (
   input wire logic        CLOCK_I,
   input wire logic        SRST_I,
   input wire logic        CE_I,
   input wire logic [7:0]  ADDR_I,
   input wire logic [31:0] WDATA_I,
   input wire logic        WR_I,
   input wire logic        RD_I,
   input wire logic [31:0] RDATA_O,
   input wire logic        SYNC_SIGNAL_O,
   input wire logic        CONV_START_O,
   input wire logic        CONV_DONE_I,
   input wire logic [1:0]  REF_SEL_O
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge CLOCK_I); endclocking
   default disable iff (SRST_I);
   wire  wr_ref = WR_I && CE_I && ADDR_I == asqtc_pkg::OFF_REF;
   wire  wr_ph  = WR_I && CE_I && ADDR_I == asqtc_pkg::OFF_PHASE;
   wire  rd_ph  = RD_I && CE_I && ADDR_I == asqtc_pkg::OFF_PHASE;
   wire  wr_pt  = WR_I && CE_I && ADDR_I == asqtc_pkg::OFF_PTRIG;
   wire  rd_lvl = RD_I && CE_I && ADDR_I[7:2] == 6'h06;
   logic [3:0] ph_q;
   logic       conv_q;
   // Shadow of the phase setting and of an open conversion
   always_ff @(posedge CLOCK_I) begin
      if (SRST_I) begin
         ph_q   <= 4'h0;
         conv_q <= 1'b0;
      end else begin
         if (wr_ph) ph_q <= WDATA_I[3:0];
         if (CONV_START_O || CONV_DONE_I) conv_q <= CONV_START_O;
      end
   end
   property p_ref_hold; $changed(REF_SEL_O) |-> $past(wr_ref); endproperty
   a_ref_hold: assert property (p_ref_hold) else $error("reference changed without write");
   property p_ref_load; wr_ref && WDATA_I[1:0] != 2'h3 |=> REF_SEL_O == $past(WDATA_I[1:0]);
   endproperty
   a_ref_load: assert property (p_ref_load) else $error("reference not loaded");
   property p_ref_legal; REF_SEL_O != 2'h3; endproperty
   a_ref_legal: assert property (p_ref_legal) else $error("illegal reference select");
   property p_ref_rst; $fell(SRST_I) |-> REF_SEL_O == 2'h0 && !CONV_START_O; endproperty
   a_ref_rst: assert property (p_ref_rst) else $error("outputs not cleared by reset");
   property p_sync; SYNC_SIGNAL_O == (wr_pt && WDATA_I[5]); endproperty
   a_sync: assert property (p_sync) else $error("signal pulse mismatch");
   property p_start_pulse; CONV_START_O |=> !CONV_START_O; endproperty
   a_start_pulse: assert property (p_start_pulse) else $error("start longer than one cycle");
   property p_one_conv; CONV_START_O |-> !conv_q; endproperty
   a_one_conv: assert property (p_one_conv) else $error("start before previous done");
   property p_phase_rd; rd_ph |=> RDATA_O[3:0] == $past(ph_q); endproperty
   a_phase_rd: assert property (p_phase_rd) else $error("phase read back wrong");
   property p_lvl; rd_lvl |=> RDATA_O <= FIFO_DEPTH; endproperty
   a_lvl: assert property (p_lvl) else $error("level above depth");
endmodule : asqtc_chk
bind asqtc_top asqtc_chk #(.FIFO_DEPTH(FIFO_DEPTH)) asqtc_chk_i (.CLOCK_I(CLOCK_I),
   .SRST_I(SRST_I), .CE_I(CE_I), .ADDR_I(ADDR_I), .WDATA_I(WDATA_I), .WR_I(WR_I),
   .RD_I(RD_I), .RDATA_O(RDATA_O), .SYNC_SIGNAL_O(SYNC_SIGNAL_O),
   .CONV_START_O(CONV_START_O), .CONV_DONE_I(CONV_DONE_I), .REF_SEL_O(REF_SEL_O));
`default_nettype wire

// [tb/asqtc_conv_model.sv]
// Behavioural converter core answering each start with one sample
`default_nettype none
module asqtc_conv_model #(
   parameter int DATA_W = 12
) (
   input  wire logic              clk_i,
   input  wire logic              rst_i,
   input  wire logic              start_i,
   output logic                   done_o,
   output logic [DATA_W-1:0]      data_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [DATA_W-1:0] cnt_q;
   int                wait_n;
   initial begin
      done_o = 1'b0;
      data_o = '0;
      cnt_q  = '0;
      wait_n = 0;
   end
   // Data toggles between answers so a stale sample never looks valid
   always @(posedge clk_i) begin
      done_o <= 1'b0;
      data_o <= ~data_o;
      if (rst_i) begin
         cnt_q  <= '0;
         wait_n <= 0;
      end else begin
         if (wait_n == 1) begin
            done_o <= 1'b1;
            data_o <= cnt_q;
            cnt_q  <= cnt_q + 1'b1;
         end
         if (start_i) wait_n <= $urandom_range(12, 1);
         else if (wait_n > 0) wait_n <= wait_n - 1;
      end
   end
endmodule : asqtc_conv_model
`default_nettype wire

// [tb/asqtc_top_tb.sv]
// Self-checking bench for the sequencer control block
`default_nettype none
module asqtc_top_tb;
   timeunit 1ns;
   timeprecision 1ns;
   localparam int PU = asqtc_pkg::PHASE_UNIT;
   logic        clk, rst, wr, rd, sig_in, ext, done, start, sync_o, rd_seen;
   logic [7:0]  addr;
   logic [31:0] wdata, rdata, rv;
   logic [2:0]  step;
   logic [1:0]  ref_o;
   logic [11:0] cdata, nd;
   logic [63:0] ent;
   logic [63:0] expq[$];
   logic [3:0]  srcs[8] = '{4'h1, 4'h2, 4'h3, 4'h5, 4'h6, 4'h7, 4'h8, 4'h9};
   logic [7:0]  rst_a[7] = '{8'h00, 8'h01, 8'h02, 8'h04, 8'h08, 8'h18, 8'h07};
   asqtc_pkg::asqtc_trig_t trig;
   int          err_total, samples_checked, cyc, starts, t0, t1, k;
   asqtc_top asqtc_top_i (.CLOCK_I(clk), .SRST_I(rst), .CE_I(1'b1), .ADDR_I(addr),
      .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .TRIG_I(trig),
      .EXT_TRIG_PIN_I(ext), .SYNC_SIGNAL_I(sig_in), .SYNC_SIGNAL_O(sync_o),
      .CONV_START_O(start), .CONV_STEP_O(step), .CONV_DONE_I(done),
      .CONV_DATA_I(cdata), .REF_SEL_O(ref_o));
   asqtc_conv_model asqtc_conv_model_i (.clk_i(clk), .rst_i(rst), .start_i(start),
      .done_o(done), .data_o(cdata));
   ////////////////////////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         err_total++;
         $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic end_of_test();
      if (err_total == 0 && samples_checked > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_of_test
   task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk);
      wr    <= 1'b1;
      addr  <= a;
      wdata <= d;
      @(posedge clk);
      wr <= 1'b0;
   endtask : wr_reg
   // Mask zero marks a read whose value is only polled
   task automatic rd_reg(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
      @(posedge clk);
      rd   <= 1'b1;
      addr <= a;
      expq.push_back({m, e});
      @(posedge clk);
      rd <= 1'b0;
      @(negedge clk);
      rv = rdata;
   endtask : rd_reg
   task automatic rd_data(input logic [7:0] s, input int n);
      repeat (n) begin
         rd_reg(asqtc_pkg::OFF_FIFO0 + s, {20'h0, nd}, 32'hFFF);
         nd++;
      end
   endtask : rd_data
   task automatic wait_idle();
      repeat (8) @(posedge clk);
      for (int i = 0; i < 400; i++) begin
         rd_reg(asqtc_pkg::OFF_STATUS, 32'h0, 32'h0);
         if (rv[12] === 1'b0) break;
      end
      check({31'h0, rv[12]}, 32'h0);
   endtask : wait_idle
   task automatic pulse(input asqtc_pkg::asqtc_trig_t t);
      @(posedge clk);
      trig <= t;
      @(posedge clk);
      trig <= '0;
   endtask : pulse
   task automatic time_start(output int t);
      wr_reg(asqtc_pkg::OFF_PTRIG, 32'h3);
      t = 0;
      while (start !== 1'b1 && t < 300) begin
         @(negedge clk);
         t++;
      end
   endtask : time_start
   function automatic asqtc_pkg::asqtc_trig_t tr(input logic [3:0] s, input logic m);
      asqtc_pkg::asqtc_trig_t t;
      t = '0;
      if (s >= 4'h1 && s <= 4'h3) t.cmp[s-4'h1] = 1'b1;
      if (s == 4'h5) t.timer = 1'b1;
      if (s >= 4'h6 && !m) t.gen_mod0[s-4'h6] = 1'b1;
      if (s >= 4'h6 && m) t.gen_mod1[s-4'h6] = 1'b1;
      return t;
   endfunction : tr
   ////////////////////////////////////////////////////////////////////////////////
   always @(posedge clk) rd_seen <= rd;
   always @(negedge clk) begin
      if (start === 1'b1) starts++;
      if (rd_seen === 1'b1 && expq.size() > 0) begin
         ent = expq.pop_front();
         if (ent[63:32] != 32'h0) check(rdata & ent[63:32], ent[31:0]);
      end
   end
   // Hang guard, far above the expected run length
   always @(posedge clk) begin
      cyc++;
      if (cyc == 30000) begin
         err_total++;
         end_of_test();
      end
   end
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   initial begin
      {rst, wr, rd, sig_in, ext, addr, wdata, nd} = {1'b1, 4'h0, 8'h0, 32'h0, 12'h0};
      trig = '0;
      void'($urandom(32'hFE7E41F0));
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      foreach (rst_a[i]) rd_reg(rst_a[i], 32'h0, 32'hFFFFFFFF);
      for (int r = 0; r < 4; r++) begin
         wr_reg(asqtc_pkg::OFF_REF, r);
         rd_reg(asqtc_pkg::OFF_REF, (r == 3) ? 32'h2 : r, 32'h3);
         check({30'h0, ref_o}, (r == 3) ? 32'h2 : r);
      end
      wr_reg(asqtc_pkg::OFF_ENABLE, 32'h8);
      time_start(t0);
      wait_idle();
      rd_data(8'h3, 1);
      k = $urandom_range(15, 1);
      wr_reg(asqtc_pkg::OFF_PHASE, k);
      rd_reg(asqtc_pkg::OFF_PHASE, k, 32'hF);
      time_start(t1);
      check(32'(t1 - t0), 32'(k * PU));
      check({29'h0, step}, 32'h0);
      wait_idle();
      rd_data(8'h3, 1);
      wr_reg(asqtc_pkg::OFF_PHASE, 32'h0);
      wr_reg(asqtc_pkg::OFF_ENABLE, 32'h0);
      wr_reg(asqtc_pkg::OFF_SEQCFG0 + 8'h3, 32'h5);
      wr_reg(asqtc_pkg::OFF_ENABLE, 32'h8);
      wr_reg(asqtc_pkg::OFF_PTRIG, 32'h3);
      repeat (20) @(posedge clk);
      rd_reg(asqtc_pkg::OFF_LEVEL0 + 8'h3, 32'h0, 32'hFF);
      foreach (srcs[i]) begin
         wr_reg(asqtc_pkg::OFF_ENABLE, 32'h0);
         wr_reg(asqtc_pkg::OFF_SEQCFG0 + 8'h3, {25'h0, 3'b100, srcs[i]});
         pulse(tr(srcs[i], 1'b1));
         repeat (10) @(posedge clk);
         rd_reg(asqtc_pkg::OFF_LEVEL0 + 8'h3, 32'h0, 32'hFF);
         wr_reg(asqtc_pkg::OFF_ENABLE, 32'h8);
         if (srcs[i] > 4'h5) pulse(tr(srcs[i], 1'b0));
         pulse(tr(srcs[i], 1'b1));
         wait_idle();
         rd_reg(asqtc_pkg::OFF_LEVEL0 + 8'h3, 32'h1, 32'hFF);
         rd_data(8'h3, 1);
      end
      wr_reg(asqtc_pkg::OFF_ENABLE, 32'h0);
      wr_reg(asqtc_pkg::OFF_SEQCFG0 + 8'h3, 32'h4);
      wr_reg(asqtc_pkg::OFF_ENABLE, 32'h8);
      ext <= 1'b1;
      wait_idle();
      rd_reg(asqtc_pkg::OFF_LEVEL0 + 8'h3, 32'h1, 32'hFF);
      rd_data(8'h3, 1);
      @(posedge clk);
      ext <= 1'b0;
      wr_reg(asqtc_pkg::OFF_ENABLE, 32'h1);
      for (int j = 0; j < 2; j++) begin
         wr_reg(asqtc_pkg::OFF_PTRIG, 32'h0);
         wait_idle();
      end
      rd_reg(asqtc_pkg::OFF_STATUS, 32'h1, 32'hF);
      rd_reg(asqtc_pkg::OFF_LEVEL0, 32'h10, 32'hFF);
      rd_data(8'h0, 16);
      rd_reg(asqtc_pkg::OFF_FIFO0, 32'h0, 32'h0);
      rd_reg(asqtc_pkg::OFF_STATUS, 32'h11, 32'hFF);
      wr_reg(asqtc_pkg::OFF_STCLR, 32'h11);
      rd_reg(asqtc_pkg::OFF_STATUS, 32'h0, 32'hFF);
      wr_reg(asqtc_pkg::OFF_ENABLE, 32'h0);
      wr_reg(asqtc_pkg::OFF_SEQCFG0 + 8'h1, 32'h15);
      wr_reg(asqtc_pkg::OFF_SEQCFG0 + 8'h2, 32'h05);
      wr_reg(asqtc_pkg::OFF_ENABLE, 32'h6);
      pulse(tr(4'h5, 1'b0));
      wait_idle();
      wait_idle();
      rd_data(8'h2, 4);
      rd_data(8'h1, 4);
      wr_reg(asqtc_pkg::OFF_ENABLE, 32'h0);
      wr_reg(asqtc_pkg::OFF_SEQCFG0 + 8'h3, 32'h0);
      wr_reg(asqtc_pkg::OFF_ENABLE, 32'h8);
      wr_reg(asqtc_pkg::OFF_PTRIG, 32'h13);
      repeat (20) @(posedge clk);
      rd_reg(asqtc_pkg::OFF_STATUS, 32'h800, 32'hFFFF);
      wr_reg(asqtc_pkg::OFF_PTRIG, 32'h23);
      wait_idle();
      rd_data(8'h3, 1);
      rd_reg(asqtc_pkg::OFF_STATUS, 32'h800, 32'hFFFF);
      @(posedge clk);
      sig_in <= 1'b1;
      wait_idle();
      @(posedge clk);
      sig_in <= 1'b0;
      rd_data(8'h3, 1);
      rd_reg(asqtc_pkg::OFF_STATUS, 32'h0, 32'hFFFF);
      wr_reg(asqtc_pkg::OFF_ENABLE, 32'h0);
      wr_reg(asqtc_pkg::OFF_SEQCFG0 + 8'h3, 32'hF);
      t0 = starts;
      wr_reg(asqtc_pkg::OFF_ENABLE, 32'h8);
      repeat (100) @(posedge clk);
      wr_reg(asqtc_pkg::OFF_ENABLE, 32'h0);
      wait_idle();
      check({31'h0, (starts - t0) > 2}, 32'h1);
      end_of_test();
   end
endmodule : asqtc_top_tb
`default_nettype wire
